// *** verilog/timer_pair_input_capture.v ***
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "timer_capture_defs.vh"

// Overview of operation
// - joined match pulses converter trigger once
// - prescaler divides by 1, 8, 64, 256
// - joined mode uses lower clock and prescaler
// - count write, enable clear, reset clear prescaler
// - disabled lower prescaler is frozen, not cleared
// - control writes leave counts untouched
// - timers stand still during sleep
// - joined match or gate fall sets flag
// - timer interrupt needs its enable bit
// - in joined mode, lower read latches upper; write restores
// - eight channels, each with own control
// - mode selects falling, rising, 4th, 16th, both
// - channel off or reset clears capture prescaler
// - qualified event stores timer into FIFO
// - not-empty set until FIFO drained
// - read returns oldest, shifts remaining entries
// - fifth event overflows, blocks until drained
// - timebase bit picks lower, default upper
// - both-edge mode: flag each edge outside sleep, no overflow
// - enabled event in idle, or interrupt-only event in sleep, requests wake
// - interrupt-only mode wakes regardless of timer
// - count field sets captures per interrupt
// - interrupt-only mode uses rising edge only
module timer_pair_input_capture #(
   parameter N = 8
) (
   // clock and reset
   input wire ref_clk,
   input wire resetn,
   // register port
   input wire [11:0] addr,
   input wire [15:0] wdata,
   input wire wr,
   input wire rd,
   output reg [15:0] rdata,
   // cpu power state
   input wire cpu_sleep,
   input wire cpu_idle,
   // pins
   input wire ext_clk_low,
   input wire ext_clk_high,
   input wire [N-1:0] cap_in,
   // events and requests
   output reg adc_trigger,
   output reg timer_irq,
   output reg [N-1:0] capture_irq,
   output reg wake_req
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function [7:0] div_end;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: div_end = `DIV1_END;
            2'h1: div_end = `DIV8_END;
            2'h2: div_end = `DIV64_END;
            default: div_end = `DIV256_END;
         endcase
      end
   endfunction

   function hit;
      input [11:0] a;
      input [11:0] target;
      begin
         hit = (a == target);
      end
   endfunction

   // ----------------------------------------------------------------
   // timer state
   // ----------------------------------------------------------------
   reg [15:0] tl_r, th_r, hold_r, pl_r, ph_r, cl_r, ch_r;
   reg [7:0] psl_r, psh_r;
   reg [1:0] tflag_r, tie_r;
   reg [2:0] xl_r, xh_r;
   reg [N-1:0] cs1_r, cs2_r, cs3_r;
   reg [N-1:0] capf_r, capie_r;

   wire wr_tl = wr & hit(addr, `ADDR_TIMER_LOW_COUNT);
   wire wr_th = wr & hit(addr, `ADDR_TIMER_HIGH_COUNT);
   wire wr_hold = wr & hit(addr, `ADDR_TIMER_HIGH_HOLDING);
   wire wr_cl = wr & hit(addr, `ADDR_TIMER_LOW_CONTROL);
   wire wr_ch = wr & hit(addr, `ADDR_TIMER_HIGH_CONTROL);
   wire rd_tl = rd & hit(addr, `ADDR_TIMER_LOW_COUNT);

   wire joined = cl_r[`TMR_JOIN_BIT];
   wire ton_l = cl_r[`TMR_ENABLE_BIT];
   wire ton_h = ch_r[`TMR_ENABLE_BIT];
   wire xl_rise = xl_r[1] & ~xl_r[2];
   wire xl_fall = ~xl_r[1] & xl_r[2];
   wire xh_rise = xh_r[1] & ~xh_r[2];
   wire xh_fall = ~xh_r[1] & xh_r[2];
   wire gate_l = cl_r[`TMR_GATE_BIT] & ~cl_r[`TMR_EXT_CLK_BIT];
   wire gate_h = ch_r[`TMR_GATE_BIT] & ~ch_r[`TMR_EXT_CLK_BIT];

   wire src_l = ~cpu_sleep & ton_l &
      (cl_r[`TMR_EXT_CLK_BIT] ? xl_rise : (gate_l ? xl_r[1] : 1'b1));
   wire src_h = ~cpu_sleep & ton_h & ~joined &
      (ch_r[`TMR_EXT_CLK_BIT] ? xh_rise : (gate_h ? xh_r[1] : 1'b1));
   wire tick_l = src_l & (psl_r == div_end(cl_r[`TMR_DIV_HI:`TMR_DIV_LO]));
   wire tick_h = src_h & (psh_r == div_end(ch_r[`TMR_DIV_HI:`TMR_DIV_LO]));

   wire match_l = (tl_r == pl_r);
   wire match_h = (th_r == ph_r);
   wire match32 = match_l & match_h;
   wire ev32 = joined & tick_l & match32;
   wire ev_h16 = tick_h & match_h;
   wire ev_l16 = ~joined & tick_l & match_l;
   wire gfall_l = ton_l & gate_l & xl_fall;
   wire gfall_h = ton_h & gate_h & xh_fall & ~joined;

   wire clr_l = ton_l & (wr_tl | (wr_th & joined) | (wr_cl & ~wdata[`TMR_ENABLE_BIT]));
   wire clr_h = wr_th | (wr_ch & ton_h & ~wdata[`TMR_ENABLE_BIT]);

   wire set_h = joined ? (ev32 | gfall_l) : (ev_h16 | gfall_h);
   wire set_l = ~joined & (ev_l16 | gfall_l);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         xl_r <= 3'h0;
         xh_r <= 3'h0;
         cs1_r <= {N{1'b0}};
         cs2_r <= {N{1'b0}};
         cs3_r <= {N{1'b0}};
      end else begin
         xl_r <= {xl_r[1:0], ext_clk_low};
         xh_r <= {xh_r[1:0], ext_clk_high};
         cs1_r <= cap_in;
         cs2_r <= cs1_r;
         cs3_r <= cs2_r;
      end
   end

   // ----------------------------------------------------------------
   // timer pair
   // ----------------------------------------------------------------
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tl_r <= 16'h0000;
         th_r <= 16'h0000;
         hold_r <= 16'h0000;
         pl_r <= `PERIOD_RESET;
         ph_r <= `PERIOD_RESET;
         cl_r <= `CONTROL_RESET;
         ch_r <= `CONTROL_RESET;
         psl_r <= 8'h00;
         psh_r <= 8'h00;
         tflag_r <= 2'h0;
         tie_r <= 2'h0;
         adc_trigger <= 1'b0;
         timer_irq <= 1'b0;
      end else begin
         if (clr_l)
            psl_r <= 8'h00;
         else if (src_l)
            psl_r <= tick_l ? 8'h00 : psl_r + 8'h01;
         if (clr_h)
            psh_r <= 8'h00;
         else if (src_h)
            psh_r <= tick_h ? 8'h00 : psh_r + 8'h01;
         if (wr_cl)
            cl_r <= wdata & `TMR_LOW_CTRL_MASK;
         if (wr_ch)
            ch_r <= wdata & `TMR_HIGH_CTRL_MASK;
         if (wr & hit(addr, `ADDR_PERIOD_LOW))
            pl_r <= wdata;
         if (wr & hit(addr, `ADDR_PERIOD_HIGH))
            ph_r <= wdata;
         if (wr_tl)
            tl_r <= wdata;
         else if (tick_l)
            tl_r <= (joined ? match32 : match_l) ? 16'h0000 : tl_r + 16'h0001;
         if (wr_tl & joined)
            th_r <= hold_r;
         else if (wr_th)
            th_r <= wdata;
         else if (joined & tick_l)
            th_r <= match32 ? 16'h0000 : (&tl_r ? th_r + 16'h0001 : th_r);
         else if (tick_h)
            th_r <= match_h ? 16'h0000 : th_r + 16'h0001;
         if (rd_tl & joined)
            hold_r <= th_r;
         else if (wr_hold)
            hold_r <= wdata;
         adc_trigger <= joined ? ev32 : ev_h16;
         if (wr & hit(addr, `ADDR_IRQ_STATUS_FIRST))
            tflag_r <= {wdata[`IRQ_HIGH_BIT] | set_h, wdata[`IRQ_LOW_BIT] | set_l};
         else
            tflag_r <= tflag_r | {set_h, set_l};
         if (wr & hit(addr, `ADDR_IRQ_ENABLE_FIRST))
            tie_r <= {wdata[`IRQ_HIGH_BIT], wdata[`IRQ_LOW_BIT]};
         timer_irq <= |(tflag_r & tie_r);
      end
   end

   // ----------------------------------------------------------------
   // capture channels
   // ----------------------------------------------------------------
   wire [N-1:0] sel_buf, sel_con, cap_set;
   wire [16*N-1:0] con_flat, head_flat;

   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : chan
         localparam integer BUF_I = `CAP_BUF_BASE + `CAP_STRIDE * i;
         localparam integer CON_I = `CAP_CON_BASE + `CAP_STRIDE * i;
         reg [15:0] con_r;
         reg [15:0] mem [0:3];
         reg [2:0] cnt_r;
         reg [3:0] pre_r;
         reg [1:0] icnt_r;
         reg lock_r, ov_r;
         reg edge_hit;
         wire [2:0] mode = con_r[2:0];
         wire rise = cs2_r[i] & ~cs3_r[i];
         wire fall = ~cs2_r[i] & cs3_r[i];
         wire [15:0] stamp = con_r[`CAP_TIMEBASE_BIT] ? tl_r : th_r;
         wire capmode = (mode != `CAP_MODE_OFF) & (mode <= `CAP_MODE_RISE16);
         wire cap_ev = edge_hit & capmode & ~cpu_sleep;
         wire irq_only_ev = (mode == `CAP_MODE_IRQ_ONLY) & rise;
         wire pop = rd & sel_buf[i] & (cnt_r != 3'h0);
         wire full = (cnt_r == 3'h4);
         wire push = cap_ev & ~lock_r & ~full;
         wire ovf = cap_ev & ~lock_r & full & ~pop & (mode != `CAP_MODE_BOTH);
         wire [2:0] wpos = cnt_r - {2'b00, pop};
         wire ici_hit = (icnt_r == con_r[`CAP_IRQ_CNT_HI:`CAP_IRQ_CNT_LO]);

         assign sel_buf[i] = hit(addr, BUF_I[11:0]);
         assign sel_con[i] = hit(addr, CON_I[11:0]);
         // every edge outside sleep flags in both-edge mode
         assign cap_set[i] = irq_only_ev |
            (cap_ev & ((mode == `CAP_MODE_BOTH) | ici_hit));
         assign con_flat[16*i +: 16] = {con_r[15:5], ov_r, cnt_r != 3'h0, con_r[2:0]};
         assign head_flat[16*i +: 16] = mem[0];

         always @* begin
            case (mode)
               `CAP_MODE_BOTH: edge_hit = rise | fall;
               `CAP_MODE_FALL: edge_hit = fall;
               `CAP_MODE_RISE: edge_hit = rise;
               `CAP_MODE_RISE4: edge_hit = rise & (pre_r == `CAP_PRE4_END);
               `CAP_MODE_RISE16: edge_hit = rise & (pre_r == `CAP_PRE16_END);
               default: edge_hit = 1'b0;
            endcase
         end

         always @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
               con_r <= `CONTROL_RESET;
               cnt_r <= 3'h0;
               pre_r <= 4'h0;
               icnt_r <= 2'h0;
               lock_r <= 1'b0;
               ov_r <= 1'b0;
            end else begin
               if (wr & sel_con[i])
                  con_r <= wdata & `CAP_CTRL_MASK;
               if (mode == `CAP_MODE_OFF)
                  pre_r <= 4'h0;
               else if (rise & ~cpu_sleep &
                        ((mode == `CAP_MODE_RISE4) | (mode == `CAP_MODE_RISE16)))
                  pre_r <= edge_hit ? 4'h0 : pre_r + 4'h1;
               if (mode == `CAP_MODE_OFF)
                  icnt_r <= 2'h0;
               else if (cap_ev & (mode != `CAP_MODE_BOTH))
                  icnt_r <= ici_hit ? 2'h0 : icnt_r + 2'h1;
               cnt_r <= cnt_r - {2'b00, pop} + {2'b00, push};
               if (ovf)
                  lock_r <= 1'b1;
               else if (cnt_r == 3'h0)
                  lock_r <= 1'b0;
               if (wr & sel_con[i])
                  ov_r <= wdata[`CAP_OVF_BIT] | ovf;
               else
                  ov_r <= ov_r | ovf;
            end
         end

         always @(posedge ref_clk) begin : fifo
            integer j;
            for (j = 0; j < 3; j = j + 1) begin
               if (pop)
                  mem[j] <= mem[j + 1];
            end
            if (push)
               mem[wpos[1:0]] <= stamp;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // capture flags, wake and outputs
   // ----------------------------------------------------------------
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         capf_r <= {N{1'b0}};
         capie_r <= {N{1'b0}};
         capture_irq <= {N{1'b0}};
         wake_req <= 1'b0;
      end else begin
         if (wr & hit(addr, `ADDR_CAPTURE_IRQ_STATUS))
            capf_r <= wdata[N-1:0] | cap_set;
         else
            capf_r <= capf_r | cap_set;
         if (wr & hit(addr, `ADDR_CAPTURE_IRQ_ENABLE))
            capie_r <= wdata[N-1:0];
         capture_irq <= capf_r & capie_r;
         wake_req <= (cpu_idle | cpu_sleep) & (|(capf_r & capie_r));
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   reg [15:0] rd_nxt;
   integer k;
   always @* begin
      rd_nxt = 16'h0000;
      case (addr)
         `ADDR_TIMER_LOW_COUNT: rd_nxt = tl_r;
         `ADDR_TIMER_HIGH_HOLDING: rd_nxt = hold_r;
         `ADDR_TIMER_HIGH_COUNT: rd_nxt = th_r;
         `ADDR_PERIOD_LOW: rd_nxt = pl_r;
         `ADDR_PERIOD_HIGH: rd_nxt = ph_r;
         `ADDR_TIMER_LOW_CONTROL: rd_nxt = cl_r;
         `ADDR_TIMER_HIGH_CONTROL: rd_nxt = ch_r;
         `ADDR_IRQ_STATUS_FIRST: rd_nxt = {8'h00, tflag_r, 6'h00};
         `ADDR_IRQ_ENABLE_FIRST: rd_nxt = {8'h00, tie_r, 6'h00};
         `ADDR_CAPTURE_IRQ_STATUS: rd_nxt = {{(16-N){1'b0}}, capf_r};
         `ADDR_CAPTURE_IRQ_ENABLE: rd_nxt = {{(16-N){1'b0}}, capie_r};
         default: begin
            for (k = 0; k < N; k = k + 1) begin
               if (sel_buf[k])
                  rd_nxt = head_flat[16*k +: 16];
               if (sel_con[k])
                  rd_nxt = con_flat[16*k +: 16];
            end
         end
      endcase
   end

   // read data valid only in the cycle after the strobe
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn)
         rdata <= 16'h0000;
      else
         rdata <= rd ? rd_nxt : 16'h0000;
   end

endmodule // timer_pair_input_capture

// *** verilog/timer_capture_defs.vh ***
`ifndef TIMER_CAPTURE_DEFS_VH
`define TIMER_CAPTURE_DEFS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADDR_TIMER_LOW_COUNT 12'h106
`define ADDR_TIMER_HIGH_HOLDING 12'h108
`define ADDR_TIMER_HIGH_COUNT 12'h10A
`define ADDR_PERIOD_LOW 12'h10C
`define ADDR_PERIOD_HIGH 12'h10E
`define ADDR_TIMER_LOW_CONTROL 12'h110
`define ADDR_TIMER_HIGH_CONTROL 12'h112
`define ADDR_IRQ_STATUS_FIRST 12'h084
`define ADDR_IRQ_ENABLE_FIRST 12'h08C
`define ADDR_CAPTURE_IRQ_STATUS 12'h086
`define ADDR_CAPTURE_IRQ_ENABLE 12'h08E
`define CAP_BUF_BASE 12'h140
`define CAP_CON_BASE 12'h142
`define CAP_STRIDE 4

// ----------------------------------------------------------------
// timer control fields
// ----------------------------------------------------------------
`define TMR_ENABLE_BIT 15
`define TMR_GATE_BIT 6
`define TMR_DIV_HI 5
`define TMR_DIV_LO 4
`define TMR_JOIN_BIT 3
`define TMR_EXT_CLK_BIT 1
`define TMR_LOW_CTRL_MASK 16'hA07A
`define TMR_HIGH_CTRL_MASK 16'hA072
`define IRQ_LOW_BIT 6
`define IRQ_HIGH_BIT 7

// ----------------------------------------------------------------
// capture control fields and modes
// ----------------------------------------------------------------
`define CAP_TIMEBASE_BIT 7
`define CAP_IRQ_CNT_HI 6
`define CAP_IRQ_CNT_LO 5
`define CAP_OVF_BIT 4
`define CAP_NE_BIT 3
`define CAP_CTRL_MASK 16'h20E7
`define CAP_MODE_OFF 3'h0
`define CAP_MODE_BOTH 3'h1
`define CAP_MODE_FALL 3'h2
`define CAP_MODE_RISE 3'h3
`define CAP_MODE_RISE4 3'h4
`define CAP_MODE_RISE16 3'h5
`define CAP_MODE_IRQ_ONLY 3'h7
`define CAP_PRE4_END 4'h3
`define CAP_PRE16_END 4'hF

// ----------------------------------------------------------------
// reset values and prescaler end counts
// ----------------------------------------------------------------
`define PERIOD_RESET 16'hFFFF
`define CONTROL_RESET 16'h0000
`define DIV1_END 8'h00
`define DIV8_END 8'h07
`define DIV64_END 8'h3F
`define DIV256_END 8'hFF

`endif

// *** sim/timer_pair_props.sv ***
`timescale 1ns/1ps
`include "timer_capture_defs.vh"
// ----------------------------------------
// port checks
// ----------------------------------------
module timer_pair_props #(
   parameter N = 8
) (
   // clock and reset
   input wire ref_clk,
   input wire resetn,
   // register port
   input wire [11:0] addr,
   input wire [15:0] wdata,
   input wire wr,
   input wire rd,
   input wire [15:0] rdata,
   // power state
   input wire cpu_sleep,
   input wire cpu_idle,
   // events
   input wire adc_trigger,
   input wire timer_irq,
   input wire [N-1:0] capture_irq,
   input wire wake_req
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   // shadow enables: masks are not visible at the ports
   reg ten_r;
   reg [N-1:0] cen_r;
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ten_r <= 1'b0;
         cen_r <= {N{1'b0}};
      end else if (wr && addr == `ADDR_IRQ_ENABLE_FIRST) begin
         ten_r <= |wdata[7:6];
      end else if (wr && addr == `ADDR_CAPTURE_IRQ_ENABLE) begin
         cen_r <= wdata[N-1:0];
      end
   end
   sequence sleeping;
      cpu_sleep [*3];
   endsequence
   sequence no_read;
      !rd;
   endsequence
   trig_pulse_a: assert property (adc_trigger |=> !adc_trigger)
      else $error("trigger held too long");
   sleep_hold_a: assert property (sleeping |-> !adc_trigger)
      else $error("trigger during sleep");
   timer_mask_a: assert property (timer_irq |-> ten_r || $past(ten_r))
      else $error("timer irq while masked");
   timer_clear_a: assert property ($fell(timer_irq) |-> $past(wr) || $past(wr, 2))
      else $error("timer irq dropped without a write");
   cap_mask_a: assert property ((capture_irq & ~(cen_r | $past(cen_r))) == '0)
      else $error("capture irq while masked");
   wake_state_a: assert property (wake_req |-> $past(cpu_idle || cpu_sleep))
      else $error("wake request while running");
   wake_follow_a: assert property ((cpu_idle && (|capture_irq) && !$past(wr)) |=> wake_req)
      else $error("no wake for pending capture");
   read_idle_a: assert property (no_read |=> rdata == 16'h0000)
      else $error("read data outside its cycle");
endmodule // timer_pair_props

bind timer_pair_input_capture timer_pair_props #(.N(N)) u_props (
   .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle), .adc_trigger(adc_trigger),
   .timer_irq(timer_irq), .capture_irq(capture_irq), .wake_req(wake_req));

// *** sim/pin_source.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// capture pin source
// ----------------------------------------
module pin_source (
   // clock
   input wire ref_clk,
   // request
   input wire go,
   input wire [2:0] ch,
   input wire [7:0] half,
   input wire [7:0] npulse,
   // pins
   output logic [7:0] cap_in,
   output logic busy
);
   integer i;
   // pins idle low; half sets a prompt or slow train
   initial begin
      cap_in = 8'h00;
      busy = 1'b0;
      forever begin
         @(posedge ref_clk);
         if (go && npulse != 8'h00) begin
            busy <= 1'b1;
            for (i = 0; i < npulse; i = i + 1) begin
               repeat (half) @(posedge ref_clk);
               cap_in[ch] <= 1'b1;
               repeat (half) @(posedge ref_clk);
               cap_in[ch] <= 1'b0;
            end
            busy <= 1'b0;
         end
      end
   end
endmodule // pin_source

// *** sim/tb_timer_pair_input_capture.sv ***
`timescale 1ns/1ps
`include "timer_capture_defs.vh"
module tb_timer_pair_input_capture;
   reg ref_clk = 1'b0;
   reg resetn = 1'b0;
   reg [11:0] addr = 12'h000;
   reg [15:0] wdata = 16'h0000;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg cpu_sleep = 1'b0;
   reg cpu_idle = 1'b0;
   reg gate_pin = 1'b0;
   reg go = 1'b0;
   reg [2:0] ch = 3'h0;
   reg [7:0] half = 8'h04;
   reg [7:0] npulse = 8'h00;
   wire [15:0] rdata;
   wire [7:0] cap_in;
   wire [7:0] capture_irq;
   wire busy;
   wire adc_trigger;
   wire timer_irq;
   wire wake_req;
   integer n_fail = 0;
   integer check_count = 0;
   integer cyc = 0;
   integer i, k, m, c;
   logic [31:0] seed = 32'h0001_3423;
   logic [15:0] d;
   logic [15:0] e [0:3];
   integer mode_t [0:4] = '{2, 3, 4, 5, 1};
   integer mul_t [0:4] = '{2, 2, 8, 32, 1};
   integer np_t [0:4] = '{5, 5, 20, 80, 3};
   integer sh_t [0:3] = '{0, 3, 6, 8};

   timer_pair_input_capture u_timer_pair_input_capture (
      .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle), .ext_clk_low(gate_pin),
      .ext_clk_high(1'b0), .cap_in(cap_in), .adc_trigger(adc_trigger),
      .timer_irq(timer_irq), .capture_irq(capture_irq), .wake_req(wake_req));
   pin_source u_pin_source (
      .ref_clk(ref_clk), .go(go), .ch(ch), .half(half), .npulse(npulse),
      .cap_in(cap_in), .busy(busy));

   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         give_verdict;
      end
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed[15:0];
   endfunction
   function automatic integer ticks(input integer n, input integer dv);
      ticks = n >> sh_t[dv];
   endfunction
   function automatic [11:0] con_a(input integer ch_n);
      con_a = `CAP_CON_BASE + 12'(4 * ch_n);
   endfunction
   task automatic wr_reg(input [11:0] a, input [15:0] v);
      @(posedge ref_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input [11:0] a, output [15:0] v);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask
   task automatic pulses(input integer n);
      @(posedge ref_clk);
      npulse <= n[7:0];
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      #1;
      while (busy) @(posedge ref_clk);
      repeat (6) @(posedge ref_clk);
   endtask
   task automatic check_eq(input [15:0] got, input [15:0] exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_near(input [15:0] got, input integer exp);
      check_count = check_count + 1;
      if ($isunknown(got) || got > exp + 2 || got + 2 < exp) begin
         n_fail = n_fail + 1;
         $display("Error at %0t: count %0d expected near %0d", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      for (i = 0; i < 7; i = i + 1) begin
         rd_reg(`ADDR_TIMER_LOW_COUNT + 12'(2 * i), d);
         check_eq(d, (i == 3 || i == 4) ? 16'hFFFF : 16'h0000);
      end
      d = rnd();
      wr_reg(`ADDR_TIMER_LOW_COUNT, d);
      wr_reg(`ADDR_TIMER_LOW_CONTROL, rnd() & 16'h0030);
      rd_reg(`ADDR_TIMER_LOW_COUNT, e[0]);
      check_eq(e[0], d);
      $display("reset values done");
      for (k = 0; k < 4; k = k + 1) begin
         wr_reg(`ADDR_TIMER_LOW_COUNT, 16'h0000);
         wr_reg(`ADDR_TIMER_LOW_CONTROL, 16'h8000 | 16'(k << 4));
         repeat (600) @(posedge ref_clk);
         wr_reg(`ADDR_TIMER_LOW_CONTROL, 16'h0000);
         rd_reg(`ADDR_TIMER_LOW_COUNT, d);
         check_near(d, ticks(601, k));
      end
      wr_reg(`ADDR_TIMER_LOW_CONTROL, 16'h8000);
      cpu_sleep <= 1'b1;
      rd_reg(`ADDR_TIMER_LOW_COUNT, d);
      repeat (20) @(posedge ref_clk);
      rd_reg(`ADDR_TIMER_LOW_COUNT, e[0]);
      check_eq(e[0], d);
      @(posedge ref_clk);
      cpu_sleep <= 1'b0;
      $display("prescaler done");
      // upper divider set to the slowest ratio, which joined mode must ignore
      wr_reg(`ADDR_TIMER_LOW_CONTROL, 16'h0008);
      wr_reg(`ADDR_TIMER_HIGH_CONTROL, 16'h0030);
      d = rnd();
      wr_reg(`ADDR_TIMER_HIGH_HOLDING, d);
      wr_reg(`ADDR_TIMER_LOW_COUNT, 16'h0005);
      wr_reg(`ADDR_TIMER_HIGH_HOLDING, 16'h0000);
      rd_reg(`ADDR_TIMER_LOW_COUNT, e[0]);
      rd_reg(`ADDR_TIMER_HIGH_HOLDING, e[1]);
      check_eq(e[0], 16'h0005);
      check_eq(e[1], d);
      wr_reg(`ADDR_PERIOD_LOW, 16'h0003);
      wr_reg(`ADDR_PERIOD_HIGH, d);
      wr_reg(`ADDR_TIMER_HIGH_HOLDING, d - 16'h0001);
      wr_reg(`ADDR_TIMER_LOW_COUNT, 16'hFFF0);
      wr_reg(`ADDR_IRQ_ENABLE_FIRST, 16'h0080);
      wr_reg(`ADDR_TIMER_LOW_CONTROL, 16'h8008);
      for (i = 0; i < 60 && adc_trigger !== 1'b1; i = i + 1) begin
         @(posedge ref_clk);
         #1;
      end
      check_near(16'(i), 20);
      check_eq({15'h0000, adc_trigger}, 16'h0001);
      rd_reg(`ADDR_IRQ_STATUS_FIRST, d);
      check_eq(d & 16'h0080, 16'h0080);
      check_eq({15'h0000, timer_irq}, 16'h0001);
      wr_reg(`ADDR_TIMER_LOW_CONTROL, 16'h0000);
      wr_reg(`ADDR_IRQ_STATUS_FIRST, 16'h0000);
      rd_reg(`ADDR_IRQ_STATUS_FIRST, d);
      check_eq({d[7], timer_irq}, 16'h0000);
      // gate fall in joined mode raises the upper flag, not the lower
      wr_reg(`ADDR_TIMER_LOW_CONTROL, 16'h8048);
      gate_pin <= 1'b1;
      repeat (8) @(posedge ref_clk);
      gate_pin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rd_reg(`ADDR_IRQ_STATUS_FIRST, d);
      check_eq(d & 16'h0080, 16'h0080);
      $display("joined timer done");
      // stamp differences need a full 16-bit wrap of the lower timer
      wr_reg(`ADDR_PERIOD_LOW, 16'hFFFF);
      wr_reg(`ADDR_TIMER_LOW_CONTROL, 16'h8000);
      for (m = 0; m < 5; m = m + 1) begin
         c = rnd() % 8;
         ch <= 3'(c);
         half <= 8'(3 + rnd() % 5);
         wr_reg(con_a(c), 16'h0000);
         wr_reg(con_a(c), 16'h0080 | 16'(mode_t[m]));
         pulses(np_t[m]);
         rd_reg(con_a(c), d);
         check_eq(d & 16'h0018, mode_t[m] == 1 ? 16'h0008 : 16'h0018);
         for (i = 0; i < 4; i = i + 1)
            rd_reg(con_a(c) - 12'h002, e[i]);
         for (i = 1; i < 4; i = i + 1)
            check_eq(e[i] - e[i - 1], 16'(mul_t[m] * half));
         rd_reg(con_a(c), d);
         check_eq(d & 16'h0008, 16'h0000);
      end
      $display("capture modes done");
      @(posedge ref_clk);
      cpu_idle <= 1'b1;
      for (k = 0; k < 4; k = k + 1) begin
         c = rnd() % 8;
         ch <= 3'(c);
         wr_reg(`ADDR_CAPTURE_IRQ_ENABLE, 16'(1 << c));
         wr_reg(con_a(c), 16'h0000);
         wr_reg(con_a(c), 16'h0083 | 16'(k << 5));
         wr_reg(`ADDR_CAPTURE_IRQ_STATUS, 16'h0000);
         pulses(k);
         rd_reg(`ADDR_CAPTURE_IRQ_STATUS, d);
         check_eq(d, 16'h0000);
         pulses(1);
         rd_reg(`ADDR_CAPTURE_IRQ_STATUS, d);
         check_eq(d, 16'(1 << c));
         check_eq({15'h0000, wake_req}, 16'h0001);
         check_eq({8'h00, capture_irq}, 16'(1 << c));
         // drain exactly what was stored
         for (i = 0; i <= k; i = i + 1)
            rd_reg(con_a(c) - 12'h002, d);
      end
      wr_reg(con_a(c), 16'h0000);
      wr_reg(`ADDR_CAPTURE_IRQ_STATUS, 16'h0000);
      pulses(2);
      rd_reg(con_a(c), d);
      check_eq(d & 16'h0008, 16'h0000);
      rd_reg(`ADDR_CAPTURE_IRQ_STATUS, d);
      check_eq(d, 16'h0000);
      $display("irq count done");
      @(posedge ref_clk);
      cpu_idle <= 1'b0;
      cpu_sleep <= 1'b1;
      wr_reg(`ADDR_TIMER_LOW_CONTROL, 16'h0000);
      wr_reg(con_a(c), 16'h0007);
      pulses(1);
      check_eq({15'h0000, wake_req}, 16'h0001);
      rd_reg(con_a(c), d);
      check_eq(d & 16'h0008, 16'h0000);
      @(posedge ref_clk);
      cpu_sleep <= 1'b0;
      $display("sleep wake done");
      give_verdict;
   end
endmodule // tb_timer_pair_input_capture
